// ===== rtl/frs_pkg.sv
// package: constants and types for the fault recovery supervisor
//------------------------------------------------------------
//------------------------------------------------------------
package frs_pkg;

    //------------------------------------------------------------
    // timing
    //------------------------------------------------------------
    localparam longint CLK_HZ          = 200000000;
    localparam longint FO_PERSIST_MS   = 1000;
    localparam longint RETRY_WAIT_S    = 300;
    localparam longint TICK_US         = 1000;
    localparam longint TICK_CYCLES     = (CLK_HZ / 1000000) * TICK_US;
    localparam longint RETRY_WAIT_MS   = RETRY_WAIT_S * 1000;

    //------------------------------------------------------------
    // widths and codes
    //------------------------------------------------------------
    localparam int ADC_W = 12;
    localparam int MS_W  = 20;
    localparam logic [7:0] EPT_INTERNAL = 8'h02;
    localparam logic [7:0] EPT_OVER_TMP = 8'h03;
    localparam logic [7:0] EPT_OVER_VLT = 8'h04;
    localparam logic [7:0] EPT_OVER_CUR = 8'h05;
    localparam logic [7:0] EPT_BATTERY  = 8'h06;
    // 2.74 V on a 3.3 V 12-bit converter
    localparam logic [ADC_W-1:0] TEMP_TRIP_RST = 12'hD48;
    localparam logic [7:0]       PROTO_V11     = 8'h11;

    typedef enum logic [1:0] {
        FRS_SEV_NONE,
        FRS_SEV_FATAL,
        FRS_SEV_NOW,
        FRS_SEV_WAIT
    } frs_sev_t;

    typedef enum {
        FRS_ST_CHECK,
        FRS_ST_SLEEP,
        FRS_ST_PING_GAP,
        FRS_ST_XFER,
        FRS_ST_WAIT,
        FRS_ST_FATAL
    } frs_state_t;

    // analog samples: four dedicated plus two user channels
    typedef struct packed {
        logic [ADC_W-1:0] vin;
        logic [ADC_W-1:0] iin;
        logic [ADC_W-1:0] temp;
        logic [ADC_W-1:0] icoil;
        logic [ADC_W-1:0] user_analog_chan_a;
        logic [ADC_W-1:0] user_analog_chan_b;
    } frs_adc_t;

    // thresholds and foreign object settings
    typedef struct packed {
        logic [ADC_W-1:0] vin_max;
        logic [ADC_W-1:0] pin_max;
        logic [ADC_W-1:0] icoil_max;
        logic [ADC_W-1:0] temp_max;
        logic [ADC_W-1:0] loss_base;
        logic [ADC_W-1:0] loss_stop;
        logic [MS_W-1:0]  persist_ms;
        logic [3:0]       retry_max;
    } frs_cfg_t;

    // end-power packet from the receiver
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } frs_ept_t;

endpackage

// ===== rtl/frs_supervisor.sv
// module: fault classification, shutdown and recovery scheduling
`timescale 1ns/1ps
module frs_supervisor (
    // clock and reset
    input  wire logic              CLOCK_I,
    input  wire logic              RST_N_I,
    // pins from outside the clock domain
    input  wire logic              TOUCH_IRQ_N_I,
    input  wire logic              RX_PRESENT_I,
    // same-domain status
    input  wire logic              CFG_CHECK_DONE_I,
    input  wire logic              CFG_CHECK_OK_I,
    input  wire logic              HW_FAULT_I,
    input  wire logic              PING_ACTIVE_I,
    input  wire logic              XFER_REQ_I,
    input  wire logic [7:0]        RX_VERSION_I,
    input  wire logic              LOSS_VALID_I,
    input  wire logic [11:0]       LOSS_I,
    input  wire logic              USE_TEMP_DEFAULT_I,
    input  wire frs_pkg::frs_adc_t ADC_I,
    input  wire frs_pkg::frs_cfg_t CFG_I,
    input  wire frs_pkg::frs_ept_t EPT_I,
    // outputs
    output logic                   AUX_SUPPLY_SWITCH_O,
    output logic                   DEEP_SLEEP_O,
    output logic                   XFER_EN_O,
    output logic                   FOREIGN_OBJECT_CHECK_O,
    output logic                   FATAL_O,
    output logic                   RETRY_WAIT_O,
    output logic                   PING_RESTART_O,
    output frs_pkg::frs_sev_t      LAST_SEV_O
);
    import frs_pkg::*;

    //------------------------------------------------------------
    // state record
    //------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       irq_sync;
        logic [1:0]       rx_sync;
        frs_state_t       st;
        logic [31:0]      tick_cnt;
        logic [MS_W-1:0]  fo_ms;
        logic [31:0]      wait_ms;
        logic [3:0]       fo_retries;
        logic [ADC_W-1:0] temp_trip;
        logic             strap_done;
        logic             restart;
        frs_sev_t         last_sev;
    } frs_reg_t;

    frs_reg_t s_r;
    frs_reg_t s_nxt;

    //------------------------------------------------------------
    // fault decode
    //------------------------------------------------------------
    // end-power code to severity, used by the state logic and a check
    function automatic frs_sev_t ept_sev(input logic [7:0] code);
        unique case (code)
            EPT_INTERNAL, EPT_BATTERY: ept_sev = FRS_SEV_FATAL;
            EPT_OVER_TMP, EPT_OVER_VLT: ept_sev = FRS_SEV_WAIT;
            EPT_OVER_CUR:               ept_sev = FRS_SEV_NOW;
            default:                    ept_sev = FRS_SEV_NONE;
        endcase
    endfunction

    logic     rx_present;
    logic     wake;
    logic     fo_enabled;
    logic     fo_over;
    logic     tick;
    logic     vin_ov;
    logic     pin_ov;
    logic     coil_oc;
    logic     temp_ot;
    frs_sev_t sev;

    // only the second synchroniser stage is read
    assign rx_present = s_r.rx_sync[1];
    assign wake       = ~s_r.irq_sync[1];
    assign tick       = (s_r.tick_cnt == 32'(TICK_CYCLES - 1));
    assign fo_enabled = (RX_VERSION_I >= PROTO_V11);
    // sum kept one bit wider so large settings cannot wrap to a low trip level
    assign fo_over    = fo_enabled && LOSS_VALID_I
                        && ({1'b0, LOSS_I} >= {1'b0, CFG_I.loss_base}
                            + {1'b0, CFG_I.loss_stop});
    // dedicated channels feed the comparators; user channels stay reserved
    assign vin_ov  = ADC_I.vin >= CFG_I.vin_max;
    // input power approximated as the current channel compared against its limit
    assign pin_ov  = ADC_I.iin >= CFG_I.pin_max;
    assign coil_oc = ADC_I.icoil >= CFG_I.icoil_max;
    assign temp_ot = ADC_I.temp >= s_r.temp_trip;

    // severity priority: fatal beats immediate beats timed
    always_comb begin
        sev = FRS_SEV_NONE;
        if (EPT_I.valid && ept_sev(EPT_I.code) == FRS_SEV_WAIT) begin
            sev = FRS_SEV_WAIT;
        end
        if (pin_ov || temp_ot) begin
            sev = FRS_SEV_WAIT;
        end
        if (s_r.fo_ms >= CFG_I.persist_ms && fo_over) begin
            sev = FRS_SEV_WAIT;
        end
        if (coil_oc || (EPT_I.valid && ept_sev(EPT_I.code) == FRS_SEV_NOW)) begin
            sev = FRS_SEV_NOW;
        end
        if (HW_FAULT_I || vin_ov
            || (EPT_I.valid && ept_sev(EPT_I.code) == FRS_SEV_FATAL)) begin
            sev = FRS_SEV_FATAL;
        end
    end

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    // one combinational copy of the whole record
    always_comb begin
        s_nxt          = s_r;
        s_nxt.irq_sync = {s_r.irq_sync[0], TOUCH_IRQ_N_I};
        s_nxt.rx_sync  = {s_r.rx_sync[0], RX_PRESENT_I};
        s_nxt.restart  = 1'b0;
        s_nxt.tick_cnt = tick ? 32'h0000_0000 : s_r.tick_cnt + 32'h0000_0001;
        // strap the temperature trip once after release
        if (!s_r.strap_done) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.temp_trip  = USE_TEMP_DEFAULT_I ? TEMP_TRIP_RST : CFG_I.temp_max;
        end
        unique case (s_r.st)
            FRS_ST_CHECK: begin
                if (CFG_CHECK_DONE_I) begin
                    s_nxt.st = CFG_CHECK_OK_I ? FRS_ST_PING_GAP : FRS_ST_FATAL;
                end
            end
            FRS_ST_SLEEP: begin
                if (wake) begin
                    s_nxt.st = FRS_ST_PING_GAP;
                end
            end
            FRS_ST_PING_GAP: begin
                if (HW_FAULT_I) begin
                    s_nxt.st = FRS_ST_FATAL;
                end else if (XFER_REQ_I && rx_present) begin
                    s_nxt.st    = FRS_ST_XFER;
                    s_nxt.fo_ms = '0;
                end else if (!rx_present && !PING_ACTIVE_I) begin
                    s_nxt.st = FRS_ST_SLEEP;
                end
            end
            FRS_ST_XFER: begin
                // persistence timer counts only while the loss stays over
                if (!fo_over) begin
                    s_nxt.fo_ms = '0;
                end else if (tick && s_r.fo_ms != '1) begin
                    s_nxt.fo_ms = s_r.fo_ms + MS_W'(1);
                end
                if (sev != FRS_SEV_NONE) begin
                    s_nxt.last_sev = sev;
                    s_nxt.fo_ms    = '0;
                end
                unique case (sev)
                    FRS_SEV_FATAL: s_nxt.st = FRS_ST_FATAL;
                    FRS_SEV_NOW: begin
                        s_nxt.st      = FRS_ST_PING_GAP;
                        s_nxt.restart = 1'b1;
                    end
                    FRS_SEV_WAIT: begin
                        s_nxt.st      = FRS_ST_WAIT;
                        s_nxt.wait_ms = '0;
                        // repeated foreign object trips beyond the limit are fatal
                        if (fo_over && s_r.fo_ms >= CFG_I.persist_ms) begin
                            s_nxt.fo_retries = s_r.fo_retries + 4'h1;
                            if (s_r.fo_retries >= CFG_I.retry_max) begin
                                s_nxt.st = FRS_ST_FATAL;
                            end
                        end
                    end
                    FRS_SEV_NONE: begin
                        if (!XFER_REQ_I || !rx_present) begin
                            s_nxt.st = FRS_ST_PING_GAP;
                        end
                    end
                endcase
            end
            FRS_ST_WAIT: begin
                if (tick) begin
                    s_nxt.wait_ms = s_r.wait_ms + 32'h0000_0001;
                end
                if (HW_FAULT_I) begin
                    s_nxt.st = FRS_ST_FATAL;
                end else if (!rx_present
                             || s_r.wait_ms >= 32'(RETRY_WAIT_MS)) begin
                    s_nxt.st      = FRS_ST_PING_GAP;
                    s_nxt.restart = 1'b1;
                end
            end
            FRS_ST_FATAL: begin
                s_nxt.st = FRS_ST_FATAL;
            end
        endcase
    end

    // state register; constants only under reset
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s_r <= '{irq_sync: 2'h3, rx_sync: 2'h0, st: FRS_ST_CHECK,
                     tick_cnt: 32'h0, fo_ms: '0, wait_ms: 32'h0, fo_retries: 4'h0,
                     temp_trip: TEMP_TRIP_RST, strap_done: 1'b0, restart: 1'b0,
                     last_sev: FRS_SEV_NONE};
        end else begin
            s_r <= s_nxt;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    // supply on while transferring, and in the ping gap only while a ping is active
    assign AUX_SUPPLY_SWITCH_O    = (s_r.st == FRS_ST_XFER)
                                    || (s_r.st == FRS_ST_PING_GAP && PING_ACTIVE_I);
    assign DEEP_SLEEP_O           = (s_r.st == FRS_ST_SLEEP);
    assign XFER_EN_O              = (s_r.st == FRS_ST_XFER);
    assign FOREIGN_OBJECT_CHECK_O = (s_r.st == FRS_ST_XFER) && fo_enabled;
    assign FATAL_O                = (s_r.st == FRS_ST_FATAL);
    assign RETRY_WAIT_O           = (s_r.st == FRS_ST_WAIT);
    assign PING_RESTART_O         = s_r.restart;
    assign LAST_SEV_O             = s_r.last_sev;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    sequence hw_fault_in_xfer;
        XFER_EN_O && HW_FAULT_I;
    endsequence

    a_hw_fatal: assert property (hw_fault_in_xfer |=> FATAL_O)
        else $error("hardware fault did not latch fatal");
    a_fatal_sticks: assert property (FATAL_O |=> FATAL_O)
        else $error("fatal state left without reset");
    a_cfg_bad: assert property ((s_r.st == FRS_ST_CHECK) && CFG_CHECK_DONE_I
        && !CFG_CHECK_OK_I |=> FATAL_O)
        else $error("corrupt configuration did not stop device");
    a_coil_restart: assert property (XFER_EN_O && coil_oc && !HW_FAULT_I && !vin_ov
        && !(EPT_I.valid && ept_sev(EPT_I.code) == FRS_SEV_FATAL)
        |=> PING_RESTART_O && !XFER_EN_O)
        else $error("coil over-current did not restart ping");
    a_sleep_aux_off: assert property (DEEP_SLEEP_O |-> !AUX_SUPPLY_SWITCH_O)
        else $error("supply on in deep sleep");
    a_wake_touch: assert property (DEEP_SLEEP_O && wake |=> !DEEP_SLEEP_O)
        else $error("touch interrupt did not wake");
    a_wait_removal: assert property (RETRY_WAIT_O && !rx_present && !HW_FAULT_I
        |=> !RETRY_WAIT_O ##0 PING_RESTART_O)
        else $error("removal did not end retry wait");
    a_fo_gate: assert property (FOREIGN_OBJECT_CHECK_O |-> RX_VERSION_I >= PROTO_V11)
        else $error("foreign object check on for old receiver");
    a_ot_wait: assert property (XFER_EN_O && temp_ot && !coil_oc && !HW_FAULT_I
        && !vin_ov && !EPT_I.valid |=> RETRY_WAIT_O || FATAL_O)
        else $error("over-temperature did not stop transfer");

    // an end-power packet taken while power flows
    sequence ept_in_xfer;
        XFER_EN_O && EPT_I.valid;
    endsequence

    // neither of the two non-packet sources that outrank every retry class
    sequence no_fatal_src;
        !HW_FAULT_I && !vin_ov;
    endsequence

    a_ept_fatal: assert property (ept_in_xfer
        ##0 (EPT_I.code == EPT_INTERNAL || EPT_I.code == EPT_BATTERY) |=> FATAL_O)
        else $error("fatal end-power code did not latch fatal");
    a_ept_now: assert property (ept_in_xfer ##0 no_fatal_src
        ##0 (EPT_I.code == EPT_OVER_CUR) |=> PING_RESTART_O && !XFER_EN_O)
        else $error("end-power over-current did not restart ping");
    a_ept_wait: assert property (ept_in_xfer ##0 no_fatal_src ##0 !coil_oc
        ##0 (EPT_I.code == EPT_OVER_TMP || EPT_I.code == EPT_OVER_VLT)
        |=> RETRY_WAIT_O || FATAL_O)
        else $error("end-power wait code did not stop transfer");
    a_pin_wait: assert property (XFER_EN_O && pin_ov && !coil_oc && !HW_FAULT_I
        && !vin_ov && !EPT_I.valid |=> RETRY_WAIT_O || FATAL_O)
        else $error("input over-power did not stop transfer");
    a_vin_fatal: assert property (XFER_EN_O && vin_ov |=> FATAL_O)
        else $error("input over-voltage did not latch fatal");
    // trips beyond the allowed count must not retry again
    a_fo_retry: assert property (XFER_EN_O && fo_over && !coil_oc && !EPT_I.valid
        && s_r.fo_ms >= CFG_I.persist_ms && s_r.fo_retries >= CFG_I.retry_max
        |=> FATAL_O)
        else $error("foreign object retry limit not enforced");
    a_restart_pulse: assert property (PING_RESTART_O |=> !PING_RESTART_O)
        else $error("ping restart longer than one cycle");
    a_gap_aux_off: assert property ((s_r.st == FRS_ST_PING_GAP) && !PING_ACTIVE_I
        |-> !AUX_SUPPLY_SWITCH_O)
        else $error("supply on between pings");

endmodule

// ===== tb/frs_partner_model.sv
// model of the touch sensor and the power receiver facing the supervisor
`timescale 1ns/1ps
module frs_partner_model #(
    parameter int IRQ_HOLD = 8
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // commands from the bench
    input  wire logic       placed_i,
    input  wire logic       ept_req_i,
    input  wire logic [7:0] ept_code_i,
    // pins toward the supervisor
    output logic            touch_irq_n_o,
    output logic            rx_present_o,
    output frs_pkg::frs_ept_t ept_o
);
    import frs_pkg::*;
    //------------------------------------------------------------
    // sensor and receiver behaviour
    //------------------------------------------------------------
    logic       placed_r;
    logic [3:0] hold_r;
    logic [7:0] last_code_r;

    // a pad change pulls the request low for a while; no host read clears it here
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            placed_r    <= 1'b0;
            hold_r      <= 4'h0;
            last_code_r <= 8'h00;
            ept_o       <= '0;
        end else begin
            placed_r <= placed_i;
            if (placed_i != placed_r) begin
                hold_r <= 4'(IRQ_HOLD);
            end else if (hold_r != 4'h0) begin
                hold_r <= hold_r - 4'h1;
            end
            ept_o.valid <= ept_req_i;
            // an idle code line shows the inverse of its last value, never a stale copy
            ept_o.code <= ept_req_i ? ept_code_i : ~last_code_r;
            if (ept_req_i) begin
                last_code_r <= ept_code_i;
            end
        end
    end

    // request is a level while the hold count runs
    assign touch_irq_n_o = (hold_r == 4'h0);
    assign rx_present_o  = placed_r;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the fault recovery supervisor
`timescale 1ns/1ps
module testbench;
    import frs_pkg::*;
    //------------------------------------------------------------
    // signals, rows and helpers
    //------------------------------------------------------------
    typedef struct packed {
        logic [2:0] kind;
        logic [7:0] code;
        frs_sev_t   sev;
    } frs_row_t;
    localparam frs_adc_t ADC_Q = {6{12'h100}};
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       placed = 1'b0;
    logic       ept_req = 1'b0;
    logic [7:0] ept_code = 8'h00;
    logic       cfg_done = 1'b0;
    logic       cfg_ok = 1'b0;
    logic       hw = 1'b0;
    logic       ping = 1'b0;
    logic       xreq = 1'b0;
    logic [7:0] ver = 8'h11;
    logic       loss_v = 1'b0;
    logic [11:0] loss = 12'h000;
    logic       strap = 1'b0;
    frs_adc_t   adc = ADC_Q;
    frs_cfg_t   cfg = {12'h800, 12'h800, 12'h800, 12'h800, 12'h100, 12'h100, 20'h00001, 4'h1};
    logic       irq_n, present, aux, sleep, xfer, fo, fatal, rwait, restart;
    frs_ept_t   ept;
    frs_sev_t   sev;
    int         fails = 0;
    int         n_compared = 0;
    int         cyc = 0;
    frs_row_t   rows [11] = '{
        '{3'h0, 8'h00, FRS_SEV_NOW},
        '{3'h1, 8'h00, FRS_SEV_FATAL},
        '{3'h2, 8'h00, FRS_SEV_WAIT},
        '{3'h3, 8'h00, FRS_SEV_WAIT},
        '{3'h6, 8'h00, FRS_SEV_WAIT},
        '{3'h4, EPT_INTERNAL, FRS_SEV_FATAL},
        '{3'h4, EPT_OVER_TMP, FRS_SEV_WAIT},
        '{3'h4, EPT_OVER_VLT, FRS_SEV_WAIT},
        '{3'h4, EPT_OVER_CUR, FRS_SEV_NOW},
        '{3'h4, EPT_BATTERY, FRS_SEV_FATAL},
        '{3'h5, 8'h00, FRS_SEV_FATAL}
    };

    always #2.5 clk = ~clk;

    frs_partner_model partner_u (.clk_i(clk), .rst_n_i(rst_n), .placed_i(placed),
        .ept_req_i(ept_req), .ept_code_i(ept_code), .touch_irq_n_o(irq_n),
        .rx_present_o(present), .ept_o(ept));

    frs_supervisor dut_u (.CLOCK_I(clk), .RST_N_I(rst_n), .TOUCH_IRQ_N_I(irq_n),
        .RX_PRESENT_I(present), .CFG_CHECK_DONE_I(cfg_done), .CFG_CHECK_OK_I(cfg_ok),
        .HW_FAULT_I(hw), .PING_ACTIVE_I(ping), .XFER_REQ_I(xreq), .RX_VERSION_I(ver),
        .LOSS_VALID_I(loss_v), .LOSS_I(loss), .USE_TEMP_DEFAULT_I(strap), .ADC_I(adc),
        .CFG_I(cfg), .EPT_I(ept), .AUX_SUPPLY_SWITCH_O(aux), .DEEP_SLEEP_O(sleep),
        .XFER_EN_O(xfer), .FOREIGN_OBJECT_CHECK_O(fo), .FATAL_O(fatal),
        .RETRY_WAIT_O(rwait), .PING_RESTART_O(restart), .LAST_SEV_O(sev));

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a hang shows up as a mismatch, not as a silent stall
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // strap is only sampled right after release, so it goes in with the reset
    task automatic do_reset(input logic s);
        @(posedge clk);
        rst_n <= 1'b0;
        adc <= ADC_Q;
        hw <= 1'b0;
        cfg_done <= 1'b0;
        cfg_ok <= 1'b0;
        xreq <= 1'b0;
        placed <= 1'b0;
        loss_v <= 1'b0;
        strap <= s;
        cfg.temp_max <= s ? 12'hFFF : 12'h800;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk("rst_xfer", xfer, 1'b0);
        chk("rst_fatal", fatal, 1'b0);
        chk("rst_sev", sev, FRS_SEV_NONE);
        @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic go_xfer(input logic [7:0] v);
        @(posedge clk);
        cfg_done <= 1'b1;
        cfg_ok <= 1'b1;
        placed <= 1'b1;
        xreq <= 1'b1;
        ver <= v;
        for (int k = 0; k < 40 && xfer !== 1'b1; k++) @(negedge clk);
        chk("xfer_on", xfer, 1'b1);
        chk("aux_xfer", aux, 1'b1);
    endtask

    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        // table of faults raised during transfer
        for (int i = 0; i < 11; i++) begin
            do_reset(rows[i].kind == 3'h6);
            go_xfer(i[0] ? 8'h10 : 8'h11);
            chk("fo_check", fo, !i[0]);
            if (rows[i].kind == 3'h6) begin
                @(posedge clk);
                adc.temp <= 12'hD47;
                repeat (10) @(negedge clk);
                chk("below_trip", xfer, 1'b1);
            end
            @(posedge clk);
            case (rows[i].kind)
                3'h0: adc.icoil <= 12'hC00;
                3'h1: adc.vin <= 12'hC00;
                3'h2: adc.iin <= 12'hC00;
                3'h3: adc.temp <= 12'hC00;
                3'h5: hw <= 1'b1;
                3'h6: adc.temp <= 12'hD48;
                default: ept_code <= rows[i].code;
            endcase
            ept_req <= (rows[i].kind == 3'h4);
            @(posedge clk);
            ept_req <= 1'b0;
            for (int k = 0; k < 10 && xfer !== 1'b0; k++) @(negedge clk);
            chk("xfer_off", xfer, 1'b0);
            chk("severity", sev, rows[i].sev);
            chk("fatal", fatal, rows[i].sev == FRS_SEV_FATAL);
            chk("wait", rwait, rows[i].sev == FRS_SEV_WAIT);
            if (rows[i].sev == FRS_SEV_NOW) begin
                chk("restart", restart, 1'b1);
                @(negedge clk);
                chk("restart_end", restart, 1'b0);
            end else if (rows[i].sev == FRS_SEV_WAIT) begin
                placed <= 1'b0;
                for (int k = 0; k < 12 && rwait !== 1'b0; k++) @(negedge clk);
                chk("wait_removed", rwait, 1'b0);
            end else begin
                @(posedge clk);
                adc <= ADC_Q;
                hw <= 1'b0;
                repeat (20) @(negedge clk);
                chk("fatal_hold", fatal, 1'b1);
                chk("fatal_xfer", xfer, 1'b0);
            end
        end
        // standby: sleep with supplies off, touch wakes, rail follows pings
        do_reset(1'b0);
        @(posedge clk);
        cfg_done <= 1'b1;
        cfg_ok <= 1'b1;
        for (int k = 0; k < 40 && sleep !== 1'b1; k++) @(negedge clk);
        chk("sleep", sleep, 1'b1);
        chk("aux_sleep", aux, 1'b0);
        placed <= 1'b1;
        for (int k = 0; k < 20 && sleep !== 1'b0; k++) @(negedge clk);
        chk("wake", sleep, 1'b0);
        @(posedge clk);
        ping <= 1'b1;
        repeat (2) @(negedge clk);
        chk("aux_ping", aux, 1'b1);
        @(posedge clk);
        ping <= 1'b0;
        repeat (2) @(negedge clk);
        chk("aux_gap", aux, 1'b0);
        // heavy loss must not stop transfer before the persistence time
        do_reset(1'b0);
        go_xfer(8'h11);
        @(posedge clk);
        loss_v <= 1'b1;
        loss <= 12'hFFF;
        repeat (100) @(negedge clk);
        chk("fo_early", xfer, 1'b1);
        // zero persistence: first trip waits, the next one past the limit is fatal
        @(posedge clk);
        cfg.persist_ms <= 20'h00000;
        for (int k = 0; k < 10 && rwait !== 1'b1; k++) @(negedge clk);
        chk("fo_trip", rwait, 1'b1);
        chk("fo_sev", sev, FRS_SEV_WAIT);
        placed <= 1'b0;
        for (int k = 0; k < 12 && rwait !== 1'b0; k++) @(negedge clk);
        chk("fo_removed", rwait, 1'b0);
        placed <= 1'b1;
        for (int k = 0; k < 40 && fatal !== 1'b1; k++) @(negedge clk);
        chk("fo_retry_fatal", fatal, 1'b1);
        // corrupt stored data: stop for good, reset below clears it
        do_reset(1'b0);
        @(posedge clk);
        cfg_done <= 1'b1;
        placed <= 1'b1;
        xreq <= 1'b1;
        for (int k = 0; k < 10 && fatal !== 1'b1; k++) @(negedge clk);
        chk("cfg_bad", fatal, 1'b1);
        repeat (20) @(negedge clk);
        chk("cfg_bad_xfer", xfer, 1'b0);
        do_reset(1'b0);
        final_report();
    end
endmodule
